// File: logic/clock_gate_pkg.sv
// package: register map, field layout and unit enumeration for the clock gating block
`default_nettype none
package clock_gate_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NUM_UNITS = 12;
  localparam logic [31:0] SYSCTL_BASE = 32'h400FE000;
  localparam logic [11:0] RUN_GATE_OFFSET = 12'h104;
  localparam logic [11:0] SLEEP_GATE_OFFSET = 12'h114;
  localparam logic [11:0] DEEP_GATE_OFFSET = 12'h124;
  localparam logic [11:0] RUN_CFG_OFFSET = 12'h060;
  localparam logic [11:0] INT_STATUS_OFFSET = 12'h200;
  localparam logic [11:0] INT_MASK_OFFSET = 12'h204;
  localparam logic [11:0] MODE_STATUS_OFFSET = 12'h208;
  localparam logic [31:0] GATE_RESET = 32'h00000000;
  localparam logic [31:0] GATE_WRITABLE = 32'h070F1017;
  localparam int AUTO_GATE_BIT = 27;
  localparam logic [31:0] RUN_CFG_WRITABLE = 32'h08000000;
  localparam logic [31:0] RUN_CFG_RESET = 32'h00000000;
  localparam int COMPARATOR_2_CLOCK_GATE_BIT = 26;
  localparam int COMPARATOR_1_CLOCK_GATE_BIT = 25;
  localparam int COMPARATOR_0_CLOCK_GATE_BIT = 24;
  localparam int GP_TIMER_3_CLOCK_GATE_BIT = 19;
  localparam int GP_TIMER_2_CLOCK_GATE_BIT = 18;
  localparam int GP_TIMER_1_CLOCK_GATE_BIT = 17;
  localparam int GP_TIMER_0_CLOCK_GATE_BIT = 16;
  localparam int TWI0_BIT = 12;
  localparam int SSER0_BIT = 4;
  localparam int ASER2_BIT = 2;
  localparam int ASER1_BIT = 1;
  localparam int ASER0_BIT = 0;
  // interrupt status bits
  localparam int EV_FAULT_BIT = 0;
  localparam int EV_MODE_BIT = 1;
  localparam int NUM_EVENTS = 2;

  typedef enum logic [1:0] {PM_RUN, PM_SLEEP, PM_DEEP} power_mode_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic fault;
    logic [3:0] unit;
  } unit_access_t;
endpackage
`default_nettype wire

// File: logic/deep_sleep_clock_gating.sv
// clock enable control for peripheral units across run, sleep and deep-sleep
//
// Local design decision: the plain strobed port.
`default_nettype none

module deep_sleep_clock_gating
  import clock_gate_pkg::*;
#(
  parameter int UNITS = NUM_UNITS
)(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  // power mode from the sequencer
  input wire logic i_sleep,
  input wire logic i_deep_sleep,
  // peripheral access from the system bus
  input wire logic i_unit_access,
  input wire logic [3:0] i_unit_sel,
  output logic o_unit_fault,
  output logic o_unit_done,
  // unit clock enables and interrupt
  output logic [UNITS-1:0] o_unit_clk_en,
  output logic o_irq
);

  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rst_n = rst_sync_reg;

  // map a 32-bit gating word to the dense unit enable vector
  function automatic logic [NUM_UNITS-1:0] unit_vec(input logic [31:0] g);
    unit_vec = {g[COMPARATOR_2_CLOCK_GATE_BIT], g[COMPARATOR_1_CLOCK_GATE_BIT], g[COMPARATOR_0_CLOCK_GATE_BIT],
                g[GP_TIMER_3_CLOCK_GATE_BIT], g[GP_TIMER_2_CLOCK_GATE_BIT], g[GP_TIMER_1_CLOCK_GATE_BIT], g[GP_TIMER_0_CLOCK_GATE_BIT],
                g[TWI0_BIT],
                g[SSER0_BIT],
                g[ASER2_BIT], g[ASER1_BIT], g[ASER0_BIT]};
  endfunction

  reg_req_t req;
  assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

  logic [31:0] run_gate_reg;
  logic [31:0] sleep_gate_reg;
  logic [31:0] deep_gate_reg;
  logic [31:0] run_cfg_reg;
  logic [NUM_EVENTS-1:0] int_status_reg;
  logic [NUM_EVENTS-1:0] int_mask_reg;
  power_mode_t mode_reg;
  power_mode_t mode_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [UNITS-1:0] clk_en_reg;
  logic fault_reg;
  logic done_reg;
  logic irq_reg;

  wire hit_run = req.addr == RUN_GATE_OFFSET;
  wire hit_sleep = req.addr == SLEEP_GATE_OFFSET;
  wire hit_deep = req.addr == DEEP_GATE_OFFSET;
  wire hit_cfg = req.addr == RUN_CFG_OFFSET;
  wire hit_ists = req.addr == INT_STATUS_OFFSET;
  wire hit_imsk = req.addr == INT_MASK_OFFSET;
  wire hit_mode = req.addr == MODE_STATUS_OFFSET;
  wire auto_gate = run_cfg_reg[AUTO_GATE_BIT];
  wire [31:0] wr_gate = req.wdata & GATE_WRITABLE;
  wire wr_run = req.wr && hit_run;
  wire wr_sleep = req.wr && hit_sleep;
  wire wr_deep = req.wr && hit_deep;
  wire wr_cfg = req.wr && hit_cfg;
  wire wr_ists = req.wr && hit_ists;
  wire wr_imsk = req.wr && hit_imsk;

  // sleep sets only count while automatic gating is on
  always_comb
  begin
    mode_next = PM_RUN;
    if (auto_gate && i_deep_sleep)
      mode_next = PM_DEEP;
    else if (auto_gate && i_sleep)
      mode_next = PM_SLEEP;
  end

  logic [31:0] active_gate;
  always_comb
  begin
    case (mode_next)
      PM_RUN: active_gate = run_gate_reg;
      PM_SLEEP: active_gate = sleep_gate_reg;
      PM_DEEP: active_gate = deep_gate_reg;
      default: active_gate = run_gate_reg;
    endcase
  end
  wire [UNITS-1:0] en_next = UNITS'(unit_vec(active_gate));

  // a fault uses the enable actually driven this cycle
  wire sel_ok = 32'(i_unit_sel) < UNITS;
  wire unit_on = sel_ok && clk_en_reg[i_unit_sel[3:0]];
  unit_access_t acc;
  assign acc = '{valid: i_unit_access, fault: i_unit_access && !unit_on, unit: i_unit_sel};
  wire mode_change = mode_next != mode_reg;
  wire [NUM_EVENTS-1:0] ev_set = {mode_change, acc.fault};
  // irq follows the status and mask landing on this edge, so a clear drops it at once
  wire [NUM_EVENTS-1:0] clear_mask = wr_ists ? req.wdata[NUM_EVENTS-1:0] : '0;
  wire [NUM_EVENTS-1:0] status_next = (int_status_reg & ~clear_mask) | ev_set;
  wire [NUM_EVENTS-1:0] mask_next = wr_imsk ? req.wdata[NUM_EVENTS-1:0] : int_mask_reg;

  logic [DATA_W-1:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    if (hit_run)
      rd_mux = run_gate_reg;
    else if (hit_sleep)
      rd_mux = sleep_gate_reg;
    else if (hit_deep)
      rd_mux = deep_gate_reg & GATE_WRITABLE;
    else if (hit_cfg)
      rd_mux = run_cfg_reg;
    else if (hit_ists)
      rd_mux = 32'(int_status_reg);
    else if (hit_imsk)
      rd_mux = 32'(int_mask_reg);
    else if (hit_mode)
      rd_mux = 32'(mode_reg);
  end

  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      run_gate_reg <= GATE_RESET;
    else if (wr_run)
      run_gate_reg <= wr_gate;
  end

  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      sleep_gate_reg <= GATE_RESET;
    else if (wr_sleep)
      sleep_gate_reg <= wr_gate;
  end

  // only unit bits ever reach the stored deep-sleep word
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      deep_gate_reg <= GATE_RESET;
    else if (wr_deep)
      deep_gate_reg <= wr_gate;
  end

  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      run_cfg_reg <= RUN_CFG_RESET;
    else if (wr_cfg)
      run_cfg_reg <= req.wdata & RUN_CFG_WRITABLE;
  end

  // set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_status_reg <= '0;
      int_mask_reg <= '0;
    end
    else
    begin
      int_status_reg <= status_next;
      int_mask_reg <= mask_next;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= PM_RUN;
      clk_en_reg <= '0;
    end
    else
    begin
      mode_reg <= mode_next;
      clk_en_reg <= en_next;
    end
  end

  // fault and done are one-cycle answers and never come together
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      fault_reg <= acc.fault;
      done_reg <= acc.valid && !acc.fault;
    end
  end

  // read data are zero outside the cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_reg <= '0;
    else
      rdata_reg <= req.rd ? rd_mux : '0;
  end

  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(status_next & mask_next);
  end

  assign o_unit_clk_en = clk_en_reg;
  assign o_unit_fault = fault_reg;
  assign o_unit_done = done_reg;
  assign o_rdata = rdata_reg;
  assign o_irq = irq_reg;

  a_reset_gates_off: assert property (@(posedge i_sys_clk)
    $rose(rst_n) |-> clk_en_reg == '0)
    else $error("unit enables not zero after reset");
  a_deep_write_follow: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (req.wr && hit_deep && auto_gate && i_deep_sleep) ##1 (auto_gate && i_deep_sleep)
      |=> o_unit_clk_en == UNITS'(unit_vec($past(req.wdata, 2))))
    else $error("deep gating write not reflected in enables");
  a_gated_faults: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (i_unit_access && sel_ok && !clk_en_reg[i_unit_sel]) |=> o_unit_fault && !o_unit_done)
    else $error("access to gated unit did not fault");
  a_enabled_completes: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (i_unit_access && unit_on) |=> !o_unit_fault && o_unit_done)
    else $error("access to clocked unit faulted");
  a_reserved_zero: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (req.rd && hit_deep) |=> (o_rdata & ~GATE_WRITABLE) == '0)
    else $error("reserved gating bits read nonzero");
  a_run_without_auto: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    !auto_gate |=> o_unit_clk_en == UNITS'(unit_vec($past(run_gate_reg))))
    else $error("run gating not in force without auto gating");
  a_deep_selects: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (auto_gate && i_deep_sleep) |=> o_unit_clk_en == UNITS'(unit_vec($past(deep_gate_reg))))
    else $error("deep-sleep set not selected");
  a_deep_readback: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (req.wr && hit_deep) ##1 (req.rd && hit_deep && !req.wr) |=>
      o_rdata == ($past(req.wdata, 2) & GATE_WRITABLE))
    else $error("deep gating register readback wrong");
  a_rdata_one_cycle: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    !req.rd |=> o_rdata == '0)
    else $error("read data outside its cycle");
  a_sleep_selects: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (auto_gate && i_sleep && !i_deep_sleep) |=>
      o_unit_clk_en == UNITS'(unit_vec($past(sleep_gate_reg))))
    else $error("sleep set not selected");
  // bit placement checked on the enables, apart from the mapping function
  a_comparator_bits: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    o_unit_clk_en[11:9] == $past({active_gate[COMPARATOR_2_CLOCK_GATE_BIT], active_gate[COMPARATOR_1_CLOCK_GATE_BIT],
      active_gate[COMPARATOR_0_CLOCK_GATE_BIT]}))
    else $error("comparator enables misplaced");
  a_timer_bits: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    o_unit_clk_en[8:5] == $past(active_gate[GP_TIMER_3_CLOCK_GATE_BIT:GP_TIMER_0_CLOCK_GATE_BIT]))
    else $error("timer enables misplaced");
  a_two_wire_bit: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    o_unit_clk_en[4] == $past(active_gate[TWI0_BIT]))
    else $error("two-wire port enable misplaced");
  a_sync_serial_bit: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    o_unit_clk_en[3] == $past(active_gate[SSER0_BIT]))
    else $error("synchronous serial enable misplaced");
  a_async_serial_bits: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    o_unit_clk_en[2:0] == $past(active_gate[ASER2_BIT:ASER0_BIT]))
    else $error("asynchronous serial enables misplaced");
  a_reserved_store: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    wr_deep |=> (deep_gate_reg & ~GATE_WRITABLE) == '0)
    else $error("reserved deep gating bits stored");
  a_gates_reserved_zero: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    ((run_gate_reg | sleep_gate_reg) & ~GATE_WRITABLE) == '0)
    else $error("reserved run or sleep gating bits stored");
  a_cfg_reserved_zero: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (run_cfg_reg & ~RUN_CFG_WRITABLE) == '0)
    else $error("reserved clock configuration bits stored");
  a_fault_flagged: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    o_unit_fault |-> int_status_reg[EV_FAULT_BIT])
    else $error("fault not recorded in status");
  a_fault_sticky: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (int_status_reg[EV_FAULT_BIT] && !(wr_ists && req.wdata[EV_FAULT_BIT])) |=>
      int_status_reg[EV_FAULT_BIT])
    else $error("fault status lost without a clear");
  a_mode_event: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    mode_change |=> int_status_reg[EV_MODE_BIT])
    else $error("mode change not recorded in status");
  a_irq_level: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    o_irq == |(int_status_reg & int_mask_reg))
    else $error("interrupt level does not follow status and mask");
  a_irq_needs_mask: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    o_irq |-> int_mask_reg != '0)
    else $error("interrupt raised with every source masked");
  a_single_answer: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    !(o_unit_fault && o_unit_done))
    else $error("fault and completion in one cycle");
  a_answer_needs_access: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    !i_unit_access |=> !o_unit_fault && !o_unit_done)
    else $error("unit answer without an access");

  c_fault_seen: cover property (@(posedge i_sys_clk) disable iff (!rst_n) o_unit_fault);
  c_deep_mode: cover property (@(posedge i_sys_clk) disable iff (!rst_n)
    mode_reg == PM_DEEP && o_unit_clk_en != '0);
  c_irq_raised: cover property (@(posedge i_sys_clk) disable iff (!rst_n) $rose(o_irq));
  c_sleep_mode: cover property (@(posedge i_sys_clk) disable iff (!rst_n) mode_reg == PM_SLEEP);
  c_write_then_read: cover property (@(posedge i_sys_clk) disable iff (!rst_n)
    wr_deep ##1 (req.rd && hit_deep));
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the deep-sleep clock gating block
`default_nettype none
module tb_top
  import clock_gate_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_sleep = 1'b0;
  logic i_deep_sleep = 1'b0;
  logic i_unit_access = 1'b0;
  logic [3:0] i_unit_sel = '0;
  logic [DATA_W-1:0] o_rdata;
  logic o_unit_fault;
  logic o_unit_done;
  logic [NUM_UNITS-1:0] o_unit_clk_en;
  logic o_irq;
  int n_fail = 0;
  int comparisons = 0;
  // one pattern per mode, together covering every unit bit
  localparam logic [31:0] RUN_PAT = 32'h1 << ASER0_BIT;
  localparam logic [31:0] DEEP_PAT = (32'h1 << COMPARATOR_2_CLOCK_GATE_BIT) | (32'h1 << COMPARATOR_0_CLOCK_GATE_BIT) |
    (32'h1 << GP_TIMER_3_CLOCK_GATE_BIT) | (32'h1 << GP_TIMER_1_CLOCK_GATE_BIT) | (32'h1 << SSER0_BIT) | (32'h1 << ASER1_BIT);
  localparam logic [31:0] SLEEP_PAT = (32'h1 << COMPARATOR_1_CLOCK_GATE_BIT) | (32'h1 << GP_TIMER_2_CLOCK_GATE_BIT) |
    (32'h1 << GP_TIMER_0_CLOCK_GATE_BIT) | (32'h1 << TWI0_BIT) | (32'h1 << ASER2_BIT);

  deep_sleep_clock_gating #(.UNITS(NUM_UNITS)) dut (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep(i_sleep),
    .i_deep_sleep(i_deep_sleep), .i_unit_access(i_unit_access), .i_unit_sel(i_unit_sel),
    .o_unit_fault(o_unit_fault), .o_unit_done(o_unit_done),
    .o_unit_clk_en(o_unit_clk_en), .o_irq(o_irq));

  initial
  begin
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  function automatic logic [31:0] unit_map(input logic [31:0] r);
    return {20'h00000, r[COMPARATOR_2_CLOCK_GATE_BIT], r[COMPARATOR_1_CLOCK_GATE_BIT], r[COMPARATOR_0_CLOCK_GATE_BIT], r[GP_TIMER_3_CLOCK_GATE_BIT],
      r[GP_TIMER_2_CLOCK_GATE_BIT], r[GP_TIMER_1_CLOCK_GATE_BIT], r[GP_TIMER_0_CLOCK_GATE_BIT], r[TWI0_BIT], r[SSER0_BIT],
      r[ASER2_BIT], r[ASER1_BIT], r[ASER0_BIT]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask

  task automatic unit_hit(input logic [3:0] u, output logic [31:0] fd);
    @(posedge i_sys_clk);
    i_unit_sel <= u;
    i_unit_access <= 1'b1;
    @(posedge i_sys_clk);
    i_unit_access <= 1'b0;
    #1 fd = {30'h0, o_unit_fault, o_unit_done};
  endtask

  // enables and irq are levels, so a few spare edges cost nothing
  task automatic settle();
    repeat (3) @(posedge i_sys_clk);
    #1;
  endtask

  // power mode pins change on an edge like every other input
  task automatic set_mode(input logic s, input logic d);
    @(posedge i_sys_clk);
    i_sleep <= s;
    i_deep_sleep <= d;
  endtask

  task automatic t_reset();
    logic [31:0] v;
    rd_reg(DEEP_GATE_OFFSET, v);
    chk(v, GATE_RESET);
    chk({20'h0, o_unit_clk_en}, 32'h0);
  endtask

  task automatic t_reserved();
    logic [31:0] v;
    @(posedge i_sys_clk);
    i_addr <= DEEP_GATE_OFFSET;
    i_wdata <= 32'hFFFFFFFF;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, GATE_WRITABLE);
    rd_reg(12'h3F0, v);
    chk(v, 32'h0);
  endtask

  task automatic t_modes();
    logic [31:0] v;
    wr_reg(RUN_GATE_OFFSET, RUN_PAT);
    wr_reg(SLEEP_GATE_OFFSET, SLEEP_PAT);
    wr_reg(DEEP_GATE_OFFSET, DEEP_PAT);
    settle();
    chk({20'h0, o_unit_clk_en}, unit_map(RUN_PAT));
    set_mode(1'b0, 1'b1);
    settle();
    chk({20'h0, o_unit_clk_en}, unit_map(RUN_PAT));
    wr_reg(RUN_CFG_OFFSET, 32'h1 << AUTO_GATE_BIT);
    settle();
    chk({20'h0, o_unit_clk_en}, unit_map(DEEP_PAT));
    rd_reg(MODE_STATUS_OFFSET, v);
    chk(v, 32'h2);
    wr_reg(DEEP_GATE_OFFSET, ~DEEP_PAT);
    settle();
    chk({20'h0, o_unit_clk_en}, unit_map(~DEEP_PAT));
    set_mode(1'b1, 1'b0);
    settle();
    chk({20'h0, o_unit_clk_en}, unit_map(SLEEP_PAT));
    set_mode(1'b0, 1'b0);
    settle();
    chk({20'h0, o_unit_clk_en}, unit_map(RUN_PAT));
    rd_reg(INT_STATUS_OFFSET, v);
    chk(v, 32'h1 << EV_MODE_BIT);
  endtask

  task automatic t_fault();
    logic [31:0] v;
    wr_reg(INT_STATUS_OFFSET, 32'h3);
    wr_reg(INT_MASK_OFFSET, 32'h1 << EV_FAULT_BIT);
    unit_hit(4'h0, v);
    chk(v, 32'h1);
    settle();
    chk({31'h0, o_irq}, 32'h0);
    unit_hit(4'h1, v);
    chk(v, 32'h2);
    settle();
    chk({31'h0, o_irq}, 32'h1);
    rd_reg(INT_STATUS_OFFSET, v);
    chk(v & 32'h1, 32'h1);
    wr_reg(INT_STATUS_OFFSET, 32'h1 << EV_FAULT_BIT);
    settle();
    chk({31'h0, o_irq}, 32'h0);
    wr_reg(INT_MASK_OFFSET, 32'h0);
    unit_hit(4'hB, v);
    chk(v, 32'h2);
    unit_hit(4'hC, v);
    chk(v, 32'h2);
    settle();
    chk({31'h0, o_irq}, 32'h0);
  endtask

  task automatic complete_run();
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #20000;
    n_fail++;
    complete_run();
  end

  initial
  begin
    repeat (16) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    t_reset();
    t_reserved();
    t_modes();
    t_fault();
    complete_run();
  end
endmodule
`default_nettype wire
